// *** core/cgfs_top.sv ***
/*
  cgfs_top: control logic of a multi-output clock generator: processor
  frequency decode, spread setting, pin 1 function mux, pair gating.
  assumes: APB master on pclk; the analog stages take rates and enables.
*/
// Implementation choices: the address map and the APB interface to the registers.
// Functional notes
// - latched select code c,b,a picks the processor clock; 111 is reserved
// - spread spectrum supported, resets to half percent down spread
// - after reset pin 1 is the shared-bus clock output
// - cleared output enable puts the shared-bus clock in high impedance
// - pin function bit: 0 shared-bus clock, 1 clock-request input
// - target bit: 0 controls reference pair 0, 1 controls pair 2
// - one pair selects between reference clock and 96 MHz display clock
// - one pair selects between processor clock and reference clock
`timescale 1ns/10ps
module cgfs_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        freq_select_a,
  input  wire logic        freq_select_b,
  input  wire logic        freq_select_c,
  input  wire logic        shared_bus_clock_out_0_i,
  output logic             shared_bus_clock_out_0_o,
  output logic             shared_bus_clock_out_0_oe,
  output logic [15:0]      cpu_rate,
  output logic             cpu_rate_reserved,
  output logic             spread_enable,
  output logic [3:0]       spread_down_tenths,
  output logic             ref_pair_0_run,
  output logic             ref_pair_2_run,
  output logic             display_pair_sel,
  output logic             cpu_ref_pair_sel,
  output logic [15:0]      ref_pair_rate,
  output logic [15:0]      bus_clock_rate,
  output logic [15:0]      serial_clock_rate,
  output logic [15:0]      display_rate
);
  typedef struct packed {
    logic        latched;
    logic [2:0]  fsel;
    logic [15:0] rate;
    logic        rsvd;
    logic        spr_en;
    logic [3:0]  spr_amt;
    logic        bus_en;
    logic [1:0]  pair_sel;
    logic        req_en;
    logic        req_tgt;
    logic [1:0]  div;
    logic        bus_clk;
    logic [31:0] rdata;
    logic        err;
  } cgfs_state_type;

  cgfs_state_type st_ff;
  cgfs_state_type nxt_st;
  logic           setup;
  logic           wr_access;
  logic           mapped;
  logic           req_active;
  logic           run0;
  logic           run2;

  assign setup     = psel && !penable;
  assign wr_access = psel && penable && pwrite && !st_ff.err;
  assign mapped    = paddr == cgfs_pkg::FREQ_STATUS_ADDR || paddr == cgfs_pkg::SPREAD_CTRL_ADDR ||
                     paddr == cgfs_pkg::OUTPUT_EN_ADDR || paddr == cgfs_pkg::PAIR_SEL_ADDR ||
                     paddr == cgfs_pkg::PIN_FUNC_ADDR;
  // request pin is only heard when the pin is an input
  assign req_active = st_ff.req_en && !shared_bus_clock_out_0_i;

  always_comb begin
    nxt_st = st_ff;
    // straps caught once, on the first edge after reset release
    if (!st_ff.latched) begin
      nxt_st.latched = 1'b1;
      nxt_st.fsel    = {freq_select_c, freq_select_b, freq_select_a};
      nxt_st.rsvd    = 1'b0;
      case ({freq_select_c, freq_select_b, freq_select_a})
        3'h0:    nxt_st.rate = cgfs_pkg::CPU_266;
        3'h1:    nxt_st.rate = cgfs_pkg::CPU_133;
        3'h2:    nxt_st.rate = cgfs_pkg::CPU_200;
        3'h3:    nxt_st.rate = cgfs_pkg::CPU_166;
        3'h4:    nxt_st.rate = cgfs_pkg::CPU_333;
        3'h5:    nxt_st.rate = cgfs_pkg::CPU_100;
        3'h6:    nxt_st.rate = cgfs_pkg::CPU_400;
        default: begin
          nxt_st.rate = 16'h0000;
          nxt_st.rsvd = 1'b1;
        end
      endcase
    end
    // 33.33 MHz: high one cycle in three, duty traded for a single clock
    nxt_st.div     = (st_ff.div == cgfs_pkg::BUS_CLK_LAST) ? 2'h0 : st_ff.div + 2'h1;
    nxt_st.bus_clk = nxt_st.div == 2'h0;
    // read data captured in setup so the access phase needs no wait
    if (setup) begin
      nxt_st.err   = !mapped;
      nxt_st.rdata = 32'h0000_0000;
      case (paddr)
        cgfs_pkg::FREQ_STATUS_ADDR: begin
          nxt_st.rdata[2:0]                    = st_ff.fsel;
          nxt_st.rdata[cgfs_pkg::RESERVED_BIT]  = st_ff.rsvd;
          nxt_st.rdata[cgfs_pkg::PAIR0_RUN_BIT] = run0;
          nxt_st.rdata[cgfs_pkg::PAIR2_RUN_BIT] = run2;
        end
        cgfs_pkg::SPREAD_CTRL_ADDR: begin
          nxt_st.rdata[cgfs_pkg::SPREAD_EN_BIT] = st_ff.spr_en;
          nxt_st.rdata[cgfs_pkg::SPREAD_AMT_LSB +: 4] = st_ff.spr_amt;
        end
        cgfs_pkg::OUTPUT_EN_ADDR: nxt_st.rdata[cgfs_pkg::BUS_CLK0_EN_BIT] = st_ff.bus_en;
        cgfs_pkg::PAIR_SEL_ADDR:  nxt_st.rdata[1:0] = st_ff.pair_sel;
        cgfs_pkg::PIN_FUNC_ADDR: begin
          nxt_st.rdata[cgfs_pkg::REQ_A_EN_BIT]   = st_ff.req_en;
          nxt_st.rdata[cgfs_pkg::REQ_TARGET_BIT] = st_ff.req_tgt;
        end
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_access) begin
      case (paddr)
        cgfs_pkg::SPREAD_CTRL_ADDR: begin
          nxt_st.spr_en  = pwdata[cgfs_pkg::SPREAD_EN_BIT];
          nxt_st.spr_amt = pwdata[cgfs_pkg::SPREAD_AMT_LSB +: 4];
        end
        cgfs_pkg::OUTPUT_EN_ADDR: nxt_st.bus_en = pwdata[cgfs_pkg::BUS_CLK0_EN_BIT];
        cgfs_pkg::PAIR_SEL_ADDR:  nxt_st.pair_sel = pwdata[1:0];
        cgfs_pkg::PIN_FUNC_ADDR: begin
          nxt_st.req_en  = pwdata[cgfs_pkg::REQ_A_EN_BIT];
          nxt_st.req_tgt = pwdata[cgfs_pkg::REQ_TARGET_BIT];
        end
        default: nxt_st.err = st_ff.err;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff          <= '0;
      st_ff.spr_en   <= cgfs_pkg::SPREAD_EN_RST;
      st_ff.spr_amt  <= cgfs_pkg::SPREAD_AMT_RST;
      st_ff.bus_en   <= cgfs_pkg::BUS_CLK0_EN_RST;
      st_ff.pair_sel <= cgfs_pkg::PAIR_SEL_RST;
      st_ff.req_en   <= cgfs_pkg::REQ_A_EN_RST;
      st_ff.req_tgt  <= cgfs_pkg::REQ_TARGET_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // a target pair stops only while the request input is heard and released
  cgfs_pair_gate #(.SETTLE(cgfs_pkg::REQ_SETTLE)) u_gate0 (
    .pclk    (pclk),
    .presetn (presetn),
    .run_req (!(st_ff.req_en && !st_ff.req_tgt) || req_active),
    .running (run0)
  );
  cgfs_pair_gate #(.SETTLE(cgfs_pkg::REQ_SETTLE)) u_gate2 (
    .pclk    (pclk),
    .presetn (presetn),
    .run_req (!(st_ff.req_en && st_ff.req_tgt) || req_active),
    .running (run2)
  );

  // host need not drop bus_en first; enable also masked by pin function
  assign shared_bus_clock_out_0_oe = st_ff.bus_en && !st_ff.req_en;
  assign shared_bus_clock_out_0_o  = st_ff.bus_clk;
  assign cpu_rate           = st_ff.rate;
  assign cpu_rate_reserved  = st_ff.rsvd;
  assign spread_enable      = st_ff.spr_en;
  assign spread_down_tenths = st_ff.spr_amt;
  assign ref_pair_0_run     = run0;
  assign ref_pair_2_run     = run2;
  assign display_pair_sel   = st_ff.pair_sel[cgfs_pkg::DISPLAY_SEL_BIT];
  assign cpu_ref_pair_sel   = st_ff.pair_sel[cgfs_pkg::CPU_REF_SEL_BIT];
  assign ref_pair_rate      = cgfs_pkg::REF_PAIR_RATE;
  assign bus_clock_rate     = cgfs_pkg::BUS_CLK_RATE;
  assign serial_clock_rate  = cgfs_pkg::SERIAL_RATE;
  assign display_rate       = cgfs_pkg::DISPLAY_RATE;
  assign prdata             = st_ff.rdata;
  assign pready             = 1'b1;
  assign pslverr            = psel && penable && st_ff.err;

  freq_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
    !st_ff.latched ##1 st_ff.latched |-> ($past(freq_select_c, 1) && $past(freq_select_b, 1)
      && $past(freq_select_a, 1)) == cpu_rate_reserved
      && (cpu_rate == 16'h0000) == cpu_rate_reserved)
    else $error("reserved select code not flagged");
  rate_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff.latched |=> $stable(cpu_rate))
    else $error("processor rate moved after latch");
  spread_reset_a: assert property (@(posedge pclk)
    $rose(presetn) |-> spread_enable == cgfs_pkg::SPREAD_EN_RST
      && spread_down_tenths == cgfs_pkg::SPREAD_AMT_RST)
    else $error("spread not at half percent down after reset");
  pin_default_a: assert property (@(posedge pclk)
    $rose(presetn) |-> shared_bus_clock_out_0_oe && !st_ff.req_en && !st_ff.req_tgt)
    else $error("pin 1 not a clock output after reset");
  hiz_when_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && paddr == cgfs_pkg::OUTPUT_EN_ADDR
      && !pwdata[cgfs_pkg::BUS_CLK0_EN_BIT] |=> !st_ff.bus_en && !shared_bus_clock_out_0_oe)
    else $error("pin driven while disabled");
  func_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && paddr == cgfs_pkg::PIN_FUNC_ADDR
      |=> st_ff.req_en == $past(pwdata[cgfs_pkg::REQ_A_EN_BIT], 1)
      && st_ff.req_tgt == $past(pwdata[cgfs_pkg::REQ_TARGET_BIT], 1))
    else $error("pin function write lost");
  target_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff.req_en && st_ff.req_tgt) [*3] |-> run0)
    else $error("untargeted pair 0 stopped");
  stop_clean_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff.req_en && !st_ff.req_tgt && shared_bus_clock_out_0_i) [*3] |-> !run0)
    else $error("pair 0 not stopped by released request");
  pair_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && paddr == cgfs_pkg::PAIR_SEL_ADDR
      |=> {cpu_ref_pair_sel, display_pair_sel} == $past(pwdata[1:0], 1))
    else $error("pair select write lost");
  bus_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
    shared_bus_clock_out_0_o |=> !shared_bus_clock_out_0_o ##1 !shared_bus_clock_out_0_o
      ##1 shared_bus_clock_out_0_o)
    else $error("shared bus clock off its divide by three");
endmodule

// *** core/cgfs_pkg.sv ***
/*
  cgfs_pkg: register map, field positions, reset values and fixed
  rates of the clock generator control block.
  assumes: 32-bit APB, one register per aligned word.
*/
package cgfs_pkg;
  // register byte addresses
  localparam logic [7:0] FREQ_STATUS_ADDR = 8'h00;
  localparam logic [7:0] SPREAD_CTRL_ADDR = 8'h04;
  localparam logic [7:0] OUTPUT_EN_ADDR   = 8'h08;
  localparam logic [7:0] PAIR_SEL_ADDR    = 8'h0c;
  localparam logic [7:0] PIN_FUNC_ADDR    = 8'h14;

  // field positions
  localparam int SPREAD_EN_BIT   = 0;
  localparam int SPREAD_AMT_LSB  = 4;
  localparam int BUS_CLK0_EN_BIT = 0;
  localparam int DISPLAY_SEL_BIT = 0;
  localparam int CPU_REF_SEL_BIT = 1;
  localparam int REQ_TARGET_BIT  = 6;
  localparam int REQ_A_EN_BIT    = 7;
  localparam int RESERVED_BIT    = 3;
  localparam int PAIR0_RUN_BIT   = 4;
  localparam int PAIR2_RUN_BIT   = 5;

  // reset values
  localparam logic       SPREAD_EN_RST   = 1'b1;
  localparam logic [3:0] SPREAD_AMT_RST  = 4'h5;   // tenths of a percent, down
  localparam logic       BUS_CLK0_EN_RST = 1'b1;
  localparam logic [1:0] PAIR_SEL_RST    = 2'h0;
  localparam logic       REQ_A_EN_RST    = 1'b0;
  localparam logic       REQ_TARGET_RST  = 1'b0;

  // timing counts
  localparam int          BUS_CLK_DIV = 3;         // 100 MHz / 3 = 33.33 MHz
  localparam logic [1:0]  BUS_CLK_LAST = 2'h2;
  localparam int          REQ_SETTLE  = 2;

  // processor clock in units of 10 kHz
  localparam logic [15:0] CPU_266 = 16'h6829;      // 26665
  localparam logic [15:0] CPU_133 = 16'h3415;      // 13333
  localparam logic [15:0] CPU_200 = 16'h4e20;      // 20000
  localparam logic [15:0] CPU_166 = 16'h411a;      // 16666
  localparam logic [15:0] CPU_333 = 16'h8235;      // 33333
  localparam logic [15:0] CPU_100 = 16'h2710;      // 10000
  localparam logic [15:0] CPU_400 = 16'h9c40;      // 40000

  // fixed secondary rates, same units
  localparam logic [15:0] REF_PAIR_RATE = 16'h2710;
  localparam logic [15:0] BUS_CLK_RATE  = 16'h0d05;
  localparam logic [15:0] SERIAL_RATE   = 16'h12c0;
  localparam logic [15:0] DISPLAY_RATE  = 16'h2580;
endpackage

// *** core/cgfs_pair_gate.sv ***
/*
  cgfs_pair_gate: clean start/stop of one reference pair.
  assumes: request is synchronous to pclk; run only moves after the
  request has held steady, so a glitching request cannot chop the pair.
*/
`timescale 1ns/10ps
module cgfs_pair_gate #(
  parameter int SETTLE = 2
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run_req,
  output logic      running
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       run;
  } cgfs_gate_type;

  cgfs_gate_type st_ff;
  cgfs_gate_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (run_req == st_ff.run) begin
      nxt_st.cnt = 4'h0;
    end else if (st_ff.cnt == 4'(SETTLE - 1)) begin
      nxt_st.run = run_req;
      nxt_st.cnt = 4'h0;
    end else begin
      nxt_st.cnt = st_ff.cnt + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{cnt: 4'h0, run: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign running = st_ff.run;

  stop_settle_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(running) |-> $past(run_req, 1) == running && $past(run_req, SETTLE) == running)
    else $error("pair run changed without a settled request");
endmodule

// *** bench/cgfs_req_src.sv ***
/*
  cgfs_req_src: board-side clock-request source sharing pin 1.
  assumes: the pin is a plain wire; the source drives only while the
  block has released it, so there is never contention.
*/
`timescale 1ns/10ps
module cgfs_req_src (
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic req_n,
  output logic      pin
);
  // released pin shows the request level, active low
  assign pin = pin_oe ? pin_o : req_n;
endmodule

// *** bench/testbench.sv ***
/*
  testbench: apb-driven regression of the clock generator control block.
  assumes: zero-wait apb slave; straps sampled once after each reset.
*/
`timescale 1ns/10ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0]  fs;
  logic        pin, pin_o, pin_oe, req_n, e;
  logic        rsv, sp_en, run0, run2, dsel, csel;
  logic [3:0]  sp_amt;
  logic [15:0] cpu_rate, ref_rate, bus_rate, ser_rate, dsp_rate;
  logic [15:0] rate_tbl [8];
  int          n_errors, cmp_count, cycles, n;

  cgfs_req_src i_src (.pin_o(pin_o), .pin_oe(pin_oe), .req_n(req_n), .pin(pin));
  cgfs_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .freq_select_a(fs[0]), .freq_select_b(fs[1]), .freq_select_c(fs[2]),
    .shared_bus_clock_out_0_i(pin), .shared_bus_clock_out_0_o(pin_o),
    .shared_bus_clock_out_0_oe(pin_oe), .cpu_rate(cpu_rate), .cpu_rate_reserved(rsv),
    .spread_enable(sp_en), .spread_down_tenths(sp_amt), .ref_pair_0_run(run0),
    .ref_pair_2_run(run2), .display_pair_sel(dsel), .cpu_ref_pair_sel(csel),
    .ref_pair_rate(ref_rate), .bus_clock_rate(bus_rate), .serial_clock_rate(ser_rate),
    .display_rate(dsp_rate)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a stuck slave is ended by the hang guard
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, r, exp);
  endtask

  task automatic do_reset(input logic [2:0] code);
    @(posedge pclk);
    presetn <= 1'b0;
    fs      <= code;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fs = 3'h0;
    req_n = 1'b0;
    rate_tbl = '{16'h6829, 16'h3415, 16'h4e20, 16'h411a, 16'h8235, 16'h2710, 16'h9c40, 16'h0};
    for (int c = 0; c < 8; c++) begin
      do_reset(c[2:0]);
      check("cpu_rate", {16'h0, cpu_rate}, {16'h0, rate_tbl[c]});
      check("reserved flag", {31'h0, rsv}, {31'h0, c == 7});
      rd_chk("status", 8'h00, {26'h0, 2'h3, c == 7, c[2:0]});
      check("ref and bus rates", {ref_rate, bus_rate}, {16'h2710, 16'h0d05});
      check("serial and display", {ser_rate, dsp_rate}, {16'h12c0, 16'h2580});
    end
    $display("test strap decode done");
    do_reset(3'h3);
    rd_chk("spread reg", 8'h04, 32'h51);
    check("spread ports", {27'h0, sp_en, sp_amt}, {27'h0, 1'b1, 4'h5});
    apb(1'b1, 8'h04, 32'h30);
    rd_chk("spread written", 8'h04, 32'h30);
    check("spread ports written", {27'h0, sp_en, sp_amt}, {27'h0, 1'b0, 4'h3});
    rd_chk("output enable", 8'h08, 32'h1);
    rd_chk("pin function", 8'h14, 32'h0);
    check("pin drives", {31'h0, pin_oe}, 32'h1);
    n = 0;
    repeat (30) begin
      @(posedge pclk);
      if (pin_o === 1'b1) n++;
    end
    check("bus clock highs", n, 32'h0000_000a);
    $display("test defaults done");
    apb(1'b1, 8'h0c, 32'h1);
    // written outputs move in the write edge's update, look half a cycle later
    @(negedge pclk);
    check("display sel", {30'h0, csel, dsel}, 32'h1);
    apb(1'b1, 8'h0c, 32'h2);
    @(negedge pclk);
    check("cpu ref sel", {30'h0, csel, dsel}, 32'h2);
    rd_chk("pair select", 8'h0c, 32'h2);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped read", {r[30:0], e}, 32'h1);
    apb(1'b1, 8'h00, 32'hff);
    rd_chk("status read only", 8'h00, 32'h33);
    $display("test selects done");
    apb(1'b1, 8'h08, 32'h0);
    @(negedge pclk);
    check("pin released", {31'h0, pin_oe}, 32'h0);
    apb(1'b1, 8'h14, 32'h80);
    req_n <= 1'b1;
    repeat (5) @(posedge pclk);
    check("pair runs stop 0", {30'h0, run2, run0}, 32'h2);
    rd_chk("status runs", 8'h00, 32'h23);
    req_n <= 1'b0;
    repeat (5) @(posedge pclk);
    check("pair runs restart", {30'h0, run2, run0}, 32'h3);
    apb(1'b1, 8'h14, 32'hc0);
    req_n <= 1'b1;
    repeat (5) @(posedge pclk);
    check("pair runs stop 2", {30'h0, run2, run0}, 32'h1);
    apb(1'b1, 8'h14, 32'h0);
    repeat (5) @(posedge pclk);
    check("request ignored", {30'h0, run2, run0}, 32'h3);
    req_n <= 1'b0;
    apb(1'b1, 8'h08, 32'h1);
    @(negedge pclk);
    check("pin drives again", {31'h0, pin_oe}, 32'h1);
    $display("test pin function done");
    finish_test();
  end
endmodule
